// ---- common/blp_pkg.sv ----
// package of the block-lock and otp protection block
// assumes a 25 MHz aclk and an AXI4-Lite master with 32-bit data
package blp_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 40;
  localparam int OTP_PROG_NS = 1000;
  localparam int OTP_PROG_CYC = (OTP_PROG_NS + CLK_NS - 1) / CLK_NS;
  // ----------------------------------------------------------------
  // geometry of the memory address
  // ----------------------------------------------------------------
  localparam int NBLK = 8;
  localparam int BLK_W = 3;
  localparam int PART_W = 1;
  localparam int NPART = 2;
  localparam int OFF_W = 9;
  localparam int OFF_LSB = 0;
  localparam int BLK_LSB = 9;
  localparam logic [OFF_W-1:0] LOCK_OFF = 9'h002;
  localparam logic [OFF_W-1:0] OTP_BASE = 9'h080;
  localparam int OTP_WORDS = 138;
  localparam logic [7:0] OTP_LAST = 8'h89;
  localparam logic [7:0] LR0_IDX = 8'h00;
  localparam logic [7:0] B1_END = 8'h08;
  localparam logic [7:0] LR1_IDX = 8'h09;
  localparam logic [15:0] LR0_RST = 16'hFFFE;
  localparam logic [63:0] FACTORY_ID = 64'h0123456789ABCDEF; // arbitrary value
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] R_ADDR = 8'h00;
  localparam logic [7:0] R_CMD = 8'h04;
  localparam logic [7:0] R_RDATA = 8'h08;
  localparam logic [7:0] R_STATUS = 8'h0C;
  localparam logic [7:0] R_LOCKS = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // command words
  // ----------------------------------------------------------------
  localparam logic [15:0] C_LOCK_SETUP = 16'h0060;
  localparam logic [15:0] C_LOCK = 16'h0001;
  localparam logic [15:0] C_UNLOCK = 16'h00D0;
  localparam logic [15:0] C_LOCKDOWN = 16'h002F;
  localparam logic [15:0] C_OTP_SETUP = 16'h00C0;
  localparam logic [15:0] C_IDENTIFICATION_READ_MODE = 16'h0090;
  localparam logic [15:0] C_READ_ST = 16'h0070;
  localparam logic [15:0] C_READ_ARR = 16'h00FF;
  localparam logic [15:0] C_CLR_ST = 16'h0050;
  // ----------------------------------------------------------------
  // status word
  // ----------------------------------------------------------------
  localparam logic [15:0] ST_RESET = 16'h0080;
  localparam logic [15:0] ST_READY = 16'h0080;
  localparam logic [15:0] ST_SEQERR = 16'h0030;
  localparam logic [15:0] ST_PGMERR = 16'h0010;
  localparam logic [15:0] ST_LOCKERR = 16'h0002;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {RM_ARRAY = 2'b00, RM_STATUS = 2'b01, RM_ID = 2'b10} blp_rmode_e;
  typedef enum logic [1:0] {PD_NONE = 2'b00, PD_LOCK = 2'b01, PD_OTP = 2'b10} blp_pend_e;
  typedef struct packed {
    logic valid;
    logic [BLK_W-1:0] blk;
  } blp_pe_req_s;
  typedef struct packed {
    logic awrdy, wrdy, aw_got, w_got, bvalid;
    logic [1:0] bresp;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic arrdy, rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [15:0] addr;
    logic [NBLK-1:0] locked, ldown;
    blp_rmode_e [NPART-1:0] rmode;
    blp_pend_e pend;
    logic [15:0] st_err;
    logic otp_busy;
    logic [15:0] otp_cnt;
    logic [7:0] otp_idx;
    logic [15:0] otp_dat;
    logic [OTP_WORDS-1:0][15:0] otp;
    logic wp_s1, wp_s2, wp_s3, wp_hi;
    logic pe_ok, pe_deny;
  } blp_state_s;
endpackage : blp_pkg

// ---- rtl/blp_protect.sv ----
// block-lock, lock-down and otp protection logic of a partitioned memory
// assumes an AXI4-Lite master on aclk and an array engine on the same clock
`timescale 1ns/1ps
module blp_protect #(
  parameter int OTP_PROG_CYC = blp_pkg::OTP_PROG_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic wp_n,
  input wire logic pe_active,
  input wire logic pgm_susp,
  input wire logic ers_susp,
  input wire blp_pkg::blp_pe_req_s pe_req,
  output logic pe_ok,
  output logic pe_deny,
  output logic [blp_pkg::NBLK-1:0] blk_locked,
  output logic otp_busy
);
  blp_pkg::blp_state_s st_r;
  blp_pkg::blp_state_s st_nxt;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [blp_pkg::BLK_W-1:0] blk;
    logic [blp_pkg::PART_W-1:0] part;
    logic [blp_pkg::OFF_W-1:0] off;
    logic [blp_pkg::OFF_W-1:0] odiff;
    logic [7:0] widx;
    logic [7:0] lrw;
    logic [3:0] lbit;
    logic in_otp;
    logic busy_run;
    logic refuse;
    logic cmd_fire;
    logic [15:0] cmd;
    logic [15:0] stw;
    logic [15:0] bus_rd;
    blk = '0;
    part = '0;
    off = '0;
    odiff = '0;
    widx = '0;
    lrw = '0;
    lbit = '0;
    in_otp = 1'b0;
    cmd_fire = 1'b0;
    cmd = '0;
    bus_rd = '0;
    busy_run = 1'b0;
    refuse = 1'b0;
    stw = '0;
    st_nxt = st_r;
    st_nxt.pe_ok = 1'b0;
    st_nxt.pe_deny = 1'b0;

    // decode of the current memory address
    blk = st_r.addr[blp_pkg::BLK_LSB +: blp_pkg::BLK_W];
    part = blk[blp_pkg::BLK_W-1 -: blp_pkg::PART_W];
    off = st_r.addr[blp_pkg::OFF_LSB +: blp_pkg::OFF_W];
    odiff = off - blp_pkg::OTP_BASE;
    widx = odiff[7:0];
    in_otp = (off >= blp_pkg::OTP_BASE) && (odiff[8] == 1'b0) && (widx <= blp_pkg::OTP_LAST);

    // otp word to its guarding lock word and bit
    if (widx == blp_pkg::LR0_IDX || widx == blp_pkg::LR1_IDX) begin
      lrw = widx;
      lbit = '0;
    end else if (widx <= blp_pkg::B1_END) begin
      lrw = blp_pkg::LR0_IDX;
      lbit = 4'((widx - 8'h01) >> 2);
    end else begin
      lrw = blp_pkg::LR1_IDX;
      lbit = 4'((widx - 8'h0A) >> 3);
    end

    // array engine state seen by the lock logic
    busy_run = pe_active && !ers_susp && !pgm_susp;
    refuse = (pe_active && !ers_susp) || pgm_susp || st_r.otp_busy;
    stw = st_r.st_err & ~blp_pkg::ST_READY;
    if (!busy_run && !st_r.otp_busy) begin
      stw = stw | blp_pkg::ST_READY;
    end

    // read cycle on the memory side
    unique case (st_r.rmode[part])
      blp_pkg::RM_STATUS: bus_rd = stw;
      blp_pkg::RM_ID: begin
        if (off == blp_pkg::LOCK_OFF) begin
          bus_rd = {14'h0000, st_r.ldown[blk], st_r.locked[blk]};
        end else if (in_otp && !st_r.otp_busy) begin
          bus_rd = st_r.otp[widx];
        end
      end
      default: bus_rd = '0;
    endcase

    // write-protect pin synchroniser
    st_nxt.wp_s1 = wp_n;
    st_nxt.wp_s2 = st_r.wp_s1;
    st_nxt.wp_s3 = st_r.wp_s2;
    if (st_r.wp_s2 == st_r.wp_s3) begin
      st_nxt.wp_hi = st_r.wp_s3;
    end

    // axi write channels
    if (awvalid && st_r.awrdy) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = awaddr;
    end
    if (wvalid && st_r.wrdy) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = wdata;
      st_nxt.wstrb = wstrb;
    end
    if (bready && st_r.bvalid) begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = blp_pkg::RESP_OKAY;
      unique case (st_r.awaddr)
        blp_pkg::R_ADDR: begin
          if (st_r.wstrb[0]) begin
            st_nxt.addr[7:0] = st_r.wdata[7:0];
          end
          if (st_r.wstrb[1]) begin
            st_nxt.addr[15:8] = st_r.wdata[15:8];
          end
        end
        blp_pkg::R_CMD: begin
          cmd_fire = (st_r.wstrb[1:0] == 2'b11);
          cmd = st_r.wdata[15:0];
        end
        blp_pkg::R_RDATA, blp_pkg::R_STATUS, blp_pkg::R_LOCKS: ;
        default: st_nxt.bresp = blp_pkg::RESP_SLVERR;
      endcase
    end
    st_nxt.awrdy = !st_nxt.aw_got && !st_nxt.bvalid;
    st_nxt.wrdy = !st_nxt.w_got && !st_nxt.bvalid;

    // command cycles on the memory side
    if (cmd_fire) begin
      unique case (st_r.pend)
        blp_pkg::PD_LOCK: begin
          st_nxt.pend = blp_pkg::PD_NONE;
          if (refuse) begin
            st_nxt.st_err = st_r.st_err | blp_pkg::ST_SEQERR;
          end else if (cmd == blp_pkg::C_LOCK) begin
            st_nxt.locked[blk] = 1'b1;
          end else if (cmd == blp_pkg::C_UNLOCK) begin
            if (!(st_r.ldown[blk] && !st_r.wp_hi)) begin
              st_nxt.locked[blk] = 1'b0;
            end
          end else if (cmd == blp_pkg::C_LOCKDOWN) begin
            st_nxt.ldown[blk] = 1'b1;
          end else begin
            st_nxt.st_err = st_r.st_err | blp_pkg::ST_SEQERR;
          end
        end
        blp_pkg::PD_OTP: begin
          st_nxt.pend = blp_pkg::PD_NONE;
          if (!in_otp || st_r.otp_busy || busy_run) begin
            st_nxt.st_err = st_r.st_err | blp_pkg::ST_PGMERR;
          end else if (widx != lrw && !st_r.otp[lrw][lbit]) begin
            st_nxt.st_err = st_r.st_err | blp_pkg::ST_PGMERR | blp_pkg::ST_LOCKERR;
          end else begin
            st_nxt.otp_busy = 1'b1;
            st_nxt.otp_cnt = 16'(OTP_PROG_CYC);
            st_nxt.otp_idx = widx;
            st_nxt.otp_dat = cmd;
          end
        end
        default: begin
          if (cmd == blp_pkg::C_LOCK_SETUP) begin
            st_nxt.pend = blp_pkg::PD_LOCK;
            st_nxt.rmode[part] = blp_pkg::RM_STATUS;
          end else if (cmd == blp_pkg::C_OTP_SETUP) begin
            st_nxt.pend = blp_pkg::PD_OTP;
            st_nxt.rmode[part] = blp_pkg::RM_STATUS;
          end else if (cmd == blp_pkg::C_IDENTIFICATION_READ_MODE) begin
            st_nxt.rmode[part] = blp_pkg::RM_ID;
          end else if (cmd == blp_pkg::C_READ_ST) begin
            st_nxt.rmode[part] = blp_pkg::RM_STATUS;
          end else if (cmd == blp_pkg::C_READ_ARR) begin
            st_nxt.rmode[part] = blp_pkg::RM_ARRAY;
          end else if (cmd == blp_pkg::C_CLR_ST) begin
            st_nxt.st_err = '0;
          end
        end
      endcase
    end

    // otp program timer; never paused by any command
    if (st_r.otp_busy) begin
      if (st_r.otp_cnt <= 16'h0001) begin
        st_nxt.otp_busy = 1'b0;
        st_nxt.otp[st_r.otp_idx] = st_r.otp[st_r.otp_idx] & st_r.otp_dat;
      end else begin
        st_nxt.otp_cnt = st_r.otp_cnt - 16'h0001;
      end
    end

    // write-protect low forces locked-down blocks locked
    if (!st_nxt.wp_hi) begin
      st_nxt.locked = st_nxt.locked | st_nxt.ldown;
    end

    // array engine program and erase gate
    if (pe_req.valid) begin
      st_nxt.pe_deny = st_r.locked[pe_req.blk];
      st_nxt.pe_ok = !st_r.locked[pe_req.blk];
    end

    // axi read channel
    if (rready && st_r.rvalid) begin
      st_nxt.rvalid = 1'b0;
    end
    if (arvalid && st_r.arrdy) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = blp_pkg::RESP_OKAY;
      st_nxt.rdata = '0;
      unique case (araddr)
        blp_pkg::R_ADDR: st_nxt.rdata = {16'h0000, st_r.addr};
        blp_pkg::R_CMD: st_nxt.rdata = '0;
        blp_pkg::R_RDATA: st_nxt.rdata = {16'h0000, bus_rd};
        blp_pkg::R_STATUS: st_nxt.rdata = {16'h0000, stw};
        blp_pkg::R_LOCKS: st_nxt.rdata = {14'h0000, st_r.otp_busy, st_r.wp_hi, st_r.ldown, st_r.locked};
        default: st_nxt.rresp = blp_pkg::RESP_SLVERR;
      endcase
    end
    st_nxt.arrdy = !st_nxt.rvalid;

    // synchronous reset to power-up state
    if (!aresetn) begin
      st_nxt = '0;
      st_nxt.locked = '1;
      st_nxt.ldown = '0;
      st_nxt.st_err = blp_pkg::ST_RESET;
      st_nxt.otp = '1;
      st_nxt.otp[0] = blp_pkg::LR0_RST;
      st_nxt.otp[1] = blp_pkg::FACTORY_ID[15:0];
      st_nxt.otp[2] = blp_pkg::FACTORY_ID[31:16];
      st_nxt.otp[3] = blp_pkg::FACTORY_ID[47:32];
      st_nxt.otp[4] = blp_pkg::FACTORY_ID[63:48];
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    st_r <= st_nxt;
  end

  // outputs straight from the state register
  assign awready = st_r.awrdy;
  assign wready = st_r.wrdy;
  assign bvalid = st_r.bvalid;
  assign bresp = st_r.bresp;
  assign arready = st_r.arrdy;
  assign rvalid = st_r.rvalid;
  assign rdata = st_r.rdata;
  assign rresp = st_r.rresp;
  assign pe_ok = st_r.pe_ok;
  assign pe_deny = st_r.pe_deny;
  assign blk_locked = st_r.locked;
  assign otp_busy = st_r.otp_busy;
endmodule : blp_protect

// ---- dv/blp_protect_monitor.sv ----
// checker of the protection block, on its ports only
// assumes a bind onto blp_protect from the bench top
`timescale 1ns/1ps
module blp_protect_monitor #(
  parameter int OTP_PROG_CYC = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic wp_n,
  input wire logic pe_active,
  input wire logic pgm_susp,
  input wire logic ers_susp,
  input wire blp_pkg::blp_pe_req_s pe_req,
  input wire logic pe_ok,
  input wire logic pe_deny,
  input wire logic [blp_pkg::NBLK-1:0] blk_locked,
  input wire logic otp_busy
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // cycles that the otp program has been busy
  logic [15:0] busy_cnt_r;
  always_ff @(posedge aclk) begin
    if (!aresetn || !otp_busy) busy_cnt_r <= 16'h0000;
    else busy_cnt_r <= busy_cnt_r + 16'h0001;
  end
  a_reset_all_locked: assert property (disable iff (1'b0) !aresetn |=> blk_locked == 8'hFF)
    else $error("blocks not locked after reset");
  a_locked_denied: assert property (pe_req.valid && blk_locked[pe_req.blk] |=> pe_deny && !pe_ok)
    else $error("request to locked block not denied");
  a_unlocked_allowed: assert property (pe_req.valid && !blk_locked[pe_req.blk] |=> pe_ok && !pe_deny)
    else $error("request to unlocked block not allowed");
  a_answer_has_cause: assert property ((pe_ok || pe_deny) |-> $past(pe_req.valid))
    else $error("answer without request");
  a_unlock_by_cmd: assert property (|($past(blk_locked) & ~blk_locked) |-> bvalid || $past(bvalid) || $past(bvalid, 2))
    else $error("block unlocked without a command");
  a_otp_full_len: assert property ($fell(otp_busy) |-> busy_cnt_r == OTP_PROG_CYC)
    else $error("otp program length wrong");
  a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read response late");
  c_deny: cover property (pe_deny);
  c_otp: cover property ($rose(otp_busy));
  c_unlock: cover property ($fell(blk_locked[3]));
endmodule : blp_protect_monitor

// ---- dv/blp_engine_model.sv ----
// model of the array engine beside the protection block
// assumes the bench calls its tasks from one thread
`timescale 1ns/1ps
module blp_engine_model (
  input wire logic aclk,
  output logic pe_active,
  output logic pgm_susp,
  output logic ers_susp,
  output blp_pkg::blp_pe_req_s pe_req
);
  // ----------------------------------------------------------------
  // engine state and requests
  // ----------------------------------------------------------------
  initial begin
    {pe_active, pgm_susp, ers_susp, pe_req} = '0;
  end
  // busy, program suspended, erase suspended
  task automatic set_mode(input logic act, input logic ps, input logic es);
    @(posedge aclk);
    {pe_active, pgm_susp, ers_susp} <= {act, ps, es};
  endtask : set_mode
  // one-cycle program or erase request
  task automatic request(input logic [2:0] blk);
    @(posedge aclk);
    pe_req <= '{valid: 1'b1, blk: blk};
    @(posedge aclk);
    pe_req <= '0;
  endtask : request
endmodule : blp_engine_model

// ---- dv/tb_blp_protect.sv ----
// self-checking bench of the protection block
// assumes blp_pkg, the engine model and the monitor are compiled first
`timescale 1ns/1ps
module tb_blp_protect;
  // ----------------------------------------------------------------
  // signals, tasks and sequence
  // ----------------------------------------------------------------
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, wp_n, awready, wready, bvalid, arready, rvalid;
  logic pe_active, pgm_susp, ers_susp, pe_ok, pe_deny, otp_busy, w;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rr, e;
  logic [blp_pkg::NBLK-1:0] blk_locked;
  logic [2:0] b;
  logic [15:0] c;
  logic [21:0] rows [9];
  blp_pkg::blp_pe_req_s pe_req;
  int errors, num_checks;
  blp_protect #(.OTP_PROG_CYC(8)) dut (.*);
  blp_engine_model eng (.aclk(aclk), .pe_active(pe_active), .pgm_susp(pgm_susp), .ers_susp(ers_susp), .pe_req(pe_req));
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    chk({30'h0, bresp, bvalid}, 32'h1);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 100);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
    chk({31'h0, rvalid}, 32'h1);
  endtask : rd
  task automatic cmd(input logic [15:0] a, input logic [15:0] d);
    wr(blp_pkg::R_ADDR, {16'h0000, a});
    wr(blp_pkg::R_CMD, {16'h0000, d});
  endtask : cmd
  task automatic lock_op(input logic [2:0] bk, input logic [15:0] cf);
    cmd({4'h0, bk, 9'h000}, 16'h0060);
    cmd({4'h0, bk, 9'h000}, cf);
    repeat (2) @(posedge aclk);
  endtask : lock_op
  task automatic id_rd(input logic [15:0] a);
    cmd(a, 16'h0090);
    rd(blp_pkg::R_RDATA, v, rr);
  endtask : id_rd
  task automatic otp_prog(input logic [8:0] off, input logic [15:0] d, input logic busy);
    int n;
    cmd(16'h0000, 16'h00C0);
    cmd({7'h00, off}, d);
    rd(blp_pkg::R_STATUS, v, rr);
    chk({31'h0, v[7]}, {31'h0, !busy});
    for (n = 0; n < 100 && otp_busy !== 1'b0; n++) @(posedge aclk);
  endtask : otp_prog
  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask : do_reset
  task automatic final_report;
    if (errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    final_report;
  end
  // wp_n, block, confirm word, expected lock-down and lock bits
  initial begin
    {errors, num_checks} = '0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    wp_n = 1'b1;
    rows = '{{1'b1, 3'd1, 16'h00D0, 2'h0}, {1'b1, 3'd1, 16'h0001, 2'h1}, {1'b1, 3'd2, 16'h00D0, 2'h0},
             {1'b1, 3'd2, 16'h002F, 2'h2}, {1'b1, 3'd3, 16'h002F, 2'h3}, {1'b1, 3'd3, 16'h00D0, 2'h2},
             {1'b0, 3'd3, 16'h00D0, 2'h3}, {1'b0, 3'd2, 16'h00D0, 2'h3}, {1'b1, 3'd2, 16'h00D0, 2'h2}};
    do_reset;
    rd(blp_pkg::R_STATUS, v, rr);
    chk(v, 32'h0080);
    rd(blp_pkg::R_LOCKS, v, rr);
    chk(v & 32'hFFFF, 32'h00FF);
    rd(blp_pkg::R_RDATA, v, rr);
    chk(v, 32'h0);
    rd(8'h20, v, rr);
    chk({30'h0, rr}, {30'h0, blp_pkg::RESP_SLVERR});
    foreach (rows[i]) begin
      {w, b, c, e} = rows[i];
      wp_n <= w;
      repeat (6) @(posedge aclk);
      lock_op(b, c);
      id_rd({4'h0, b, 9'h002});
      chk(v, {30'h0, e});
      chk({31'h0, blk_locked[b]}, {31'h0, e[0]});
    end
    cmd(16'h0800, 16'h0060);
    rd(blp_pkg::R_RDATA, v, rr);
    chk(v, 32'h0080);
    cmd(16'h0800, 16'h00D0);
    eng.request(3'd4);
    @(posedge aclk);
    chk({30'h0, pe_deny, pe_ok}, 32'h1);
    eng.request(3'd3);
    @(posedge aclk);
    chk({30'h0, pe_deny, pe_ok}, 32'h2);
    eng.set_mode(1'b1, 1'b0, 1'b0);
    lock_op(3'd4, 16'h0001);
    chk({31'h0, blk_locked[4]}, 32'h0);
    rd(blp_pkg::R_STATUS, v, rr);
    chk(v & 32'h30, 32'h30);
    cmd(16'h0000, 16'h0050);
    eng.set_mode(1'b1, 1'b0, 1'b1);
    lock_op(3'd4, 16'h0001);
    chk({31'h0, blk_locked[4]}, 32'h1);
    eng.set_mode(1'b1, 1'b1, 1'b1);
    lock_op(3'd4, 16'h00D0);
    chk({31'h0, blk_locked[4]}, 32'h1);
    eng.set_mode(1'b0, 1'b0, 1'b0);
    cmd(16'h0000, 16'h0050);
    otp_prog(9'h085, 16'hFF0F, 1'b1);
    id_rd(16'h0085);
    chk(v, 32'hFF0F);
    otp_prog(9'h085, 16'hF0FF, 1'b1);
    id_rd(16'h0085);
    chk(v, 32'hF00F);
    otp_prog(9'h081, 16'h0000, 1'b0);
    chk(v & 32'h12, 32'h12);
    id_rd(16'h0081);
    chk(v, {16'h0000, blp_pkg::FACTORY_ID[15:0]});
    cmd(16'h0000, 16'h0050);
    otp_prog(9'h10A, 16'h0000, 1'b0);
    chk(v & 32'h12, 32'h10);
    cmd(16'h0800, 16'h0070);
    rd(blp_pkg::R_RDATA, v, rr);
    chk(v, 32'h0090);
    cmd(16'h0800, 16'h00FF);
    rd(blp_pkg::R_RDATA, v, rr);
    chk(v, 32'h0);
    do_reset;
    rd(blp_pkg::R_LOCKS, v, rr);
    chk(v & 32'hFFFF, 32'h00FF);
    final_report;
  end
endmodule : tb_blp_protect
bind blp_protect blp_protect_monitor #(.OTP_PROG_CYC(OTP_PROG_CYC)) u_mon (.*);
